// [src/dsr_map.svh]
`ifndef DSR_MAP_SVH
`define DSR_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define DSR_IDX_PAGE        12'h008
`define DSR_IDX_ROT_GATE    12'h03b
`define DSR_IDX_GAIN_CTRL   12'h580
`define DSR_IDX_TRIG_EN     12'h581
`define DSR_IDX_SOFT_ON     12'h582
`define DSR_IDX_STATUS      12'h5a0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSR_BIT_MASTER_EN   7
`define DSR_RATE_MSB        2
`define DSR_BIT_SHORT_EN    7
`define DSR_BIT_LONG_EN     6
`define DSR_BIT_LINK_EN     3
`define DSR_BIT_ROT_EN      2
`define DSR_BIT_PIN_EN      1
`define DSR_BIT_FORCE_OFF   0
`define DSR_BIT_FORCE_ON    7
`define DSR_BIT_ROT_GATE    0

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define DSR_RST_GAIN_CTRL   8'h00
`define DSR_RST_TRIG_EN     8'hc6
`define DSR_RST_SOFT_ON     8'h40
`define DSR_RST_PAGE        8'h03
`define DSR_RST_ROT_GATE    8'h00
`define DSR_MASK_GAIN_CTRL  8'h87
`define DSR_MASK_TRIG_EN    8'hcf
`define DSR_MASK_SOFT_ON    8'hff
`define DSR_MASK_PAGE       8'h03
`define DSR_MASK_ROT_GATE   8'h01

// ----------------------------------------
// Ramp timing and bus answers
// ----------------------------------------
`define DSR_RAMP_STEPS      32
`define DSR_RAMP_EXP_BASE   8
`define DSR_RESP_OKAY       2'b00
`define DSR_RESP_SLVERR     2'b10

`endif

// [src/dsr_pkg.sv]
package dsr_pkg;

  // Gray coded along ON -> DOWN -> OFF -> UP -> ON
  typedef enum logic [1:0] {
    DSR_ON   = 2'b00,
    DSR_DOWN = 2'b01,
    DSR_OFF  = 2'b11,
    DSR_UP   = 2'b10
  } dsr_state_t;

  typedef enum logic [2:0] {
    DSR_R_NONE, DSR_R_PAGE, DSR_R_ROT, DSR_R_CTRL, DSR_R_TRIG, DSR_R_SON, DSR_R_STAT
  } dsr_reg_t;

  typedef struct packed {
    logic shortPowerErr;
    logic longPowerErr;
  } dsr_err_t;

endpackage : dsr_pkg

// [src/dsr_soft_off_ramp.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "dsr_map.svh"

module dsr_soft_off_ramp #(
  parameter int NUM_CONV = 2,
  parameter int RAMP_STEPS = `DSR_RAMP_STEPS,
  parameter int RAMP_EXP_BASE = `DSR_RAMP_EXP_BASE,
  localparam int GAIN_W = $clog2(RAMP_STEPS) + 1
) (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  // AXI4-Lite slave
  input  wire logic [15:0]                      s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [15:0]                      s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Soft off sources
  input  wire dsr_pkg::dsr_err_t [NUM_CONV-1:0] powerErr,
  input  wire logic                             linkErr,
  input  wire logic                             syncRotate,
  input  wire logic [NUM_CONV-1:0]              transmit_enable_pin,
  // Gain to the converter datapath
  output logic [NUM_CONV-1:0][GAIN_W-1:0]       gainLevel,
  output logic [NUM_CONV-1:0]                   rampBusy
);
  import dsr_pkg::*;

  localparam int STEP_SHIFT = RAMP_EXP_BASE - $clog2(RAMP_STEPS);
  localparam int CNT_W = STEP_SHIFT + 8;
  localparam logic [GAIN_W-1:0] GAIN_ONE = GAIN_W'(RAMP_STEPS);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic dsr_reg_t decodeReg(input logic [15:0] a);
    case (a)
      {2'b00, `DSR_IDX_PAGE, 2'b00}:      decodeReg = DSR_R_PAGE;
      {2'b00, `DSR_IDX_ROT_GATE, 2'b00}:  decodeReg = DSR_R_ROT;
      {2'b00, `DSR_IDX_GAIN_CTRL, 2'b00}: decodeReg = DSR_R_CTRL;
      {2'b00, `DSR_IDX_TRIG_EN, 2'b00}:   decodeReg = DSR_R_TRIG;
      {2'b00, `DSR_IDX_SOFT_ON, 2'b00}:   decodeReg = DSR_R_SON;
      {2'b00, `DSR_IDX_STATUS, 2'b00}:    decodeReg = DSR_R_STAT;
      default:                            decodeReg = DSR_R_NONE;
    endcase
  endfunction : decodeReg

  logic [15:0] awAddr_q;
  logic        awHave_q;
  logic [7:0]  wData_q;
  logic        wLane0_q;
  logic        wHave_q;
  logic        wrGo;
  logic        rdGo;
  logic        wrEn;
  dsr_reg_t    wrSel;
  logic [7:0]  page_q;
  logic [7:0]  rotGate_q;
  logic [7:0]  ctrl_q [NUM_CONV];
  logic [7:0]  trig_q [NUM_CONV];
  logic [7:0]  softOn_q [NUM_CONV];
  logic [7:0]  stat [NUM_CONV];
  logic [7:0]  rdByte;

  assign wrGo  = awHave_q & wHave_q & ~s_axi_bvalid;
  assign rdGo  = s_axi_arvalid & s_axi_arready;
  assign wrSel = decodeReg(awAddr_q);
  // Registers are eight bits wide, so only lane 0 matters
  assign wrEn  = wrGo & wLane0_q;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHave_q      <= 1'b0;
      awAddr_q      <= 16'h0000;
      s_axi_awready <= 1'b1;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrGo) begin
        awHave_q <= 1'b0;
      end
      s_axi_awready <= ~((s_axi_awvalid & s_axi_awready) | (awHave_q & ~wrGo));
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHave_q      <= 1'b0;
      wData_q      <= 8'h00;
      wLane0_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_q  <= 1'b1;
        wData_q  <= s_axi_wdata[7:0];
        wLane0_q <= s_axi_wstrb[0];
      end else if (wrGo) begin
        wHave_q <= 1'b0;
      end
      s_axi_wready <= ~((s_axi_wvalid & s_axi_wready) | (wHave_q & ~wrGo));
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DSR_RESP_OKAY;
    end else if (wrGo) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wrSel == DSR_R_NONE) ? `DSR_RESP_SLVERR : `DSR_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_q    <= `DSR_RST_PAGE;
      rotGate_q <= `DSR_RST_ROT_GATE;
    end else if (wrEn) begin
      if (wrSel == DSR_R_PAGE) begin
        page_q <= wData_q & `DSR_MASK_PAGE;
      end
      if (wrSel == DSR_R_ROT) begin
        rotGate_q <= wData_q & `DSR_MASK_ROT_GATE;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  // Reads show the lowest selected converter; several may take a write
  always_comb begin
    int rdConv;
    rdConv = 0;
    for (int k = NUM_CONV - 1; k >= 0; k--) begin
      if (page_q[k]) begin
        rdConv = k;
      end
    end
    case (decodeReg(s_axi_araddr))
      DSR_R_PAGE: rdByte = page_q;
      DSR_R_ROT:  rdByte = rotGate_q;
      DSR_R_CTRL: rdByte = ctrl_q[rdConv];
      DSR_R_TRIG: rdByte = trig_q[rdConv];
      DSR_R_SON:  rdByte = softOn_q[rdConv];
      DSR_R_STAT: rdByte = stat[rdConv];
      default:    rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DSR_RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else begin
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rdByte};
        s_axi_rresp  <= (decodeReg(s_axi_araddr) == DSR_R_NONE) ? `DSR_RESP_SLVERR : `DSR_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~(rdGo | (s_axi_rvalid & ~s_axi_rready));
    end
  end

  // ----------------------------------------
  // Per-converter ramp engines
  // ----------------------------------------
  for (genvar i = 0; i < NUM_CONV; i++) begin : g_conv
    dsr_state_t        state_q;
    logic [GAIN_W-1:0] gain_q;
    logic [CNT_W-1:0]  stepCnt_q;
    logic [CNT_W-1:0]  stepLim;
    logic [CNT_W-1:0]  sinceChg_q;
    logic              pinS1_q;
    logic              pinS2_q;
    logic              pinS3_q;
    logic              pinLvl_q;
    logic              pinFall;
    logic              selW;
    logic              en;
    logic              offReq;
    logic              takeOff;
    logic              takeOn;
    logic              stepDone;

    assign selW     = wrEn & page_q[i];
    assign en       = ctrl_q[i][`DSR_BIT_MASTER_EN];
    assign stepLim  = CNT_W'((32'h1 << (32'(ctrl_q[i][`DSR_RATE_MSB:0]) + STEP_SHIFT)) - 32'h1);
    assign stepDone = en & (stepCnt_q == stepLim);
    assign pinFall  = (pinS2_q == pinS3_q) & ~pinS2_q & pinLvl_q;
    assign offReq   = (trig_q[i][`DSR_BIT_SHORT_EN] & powerErr[i].shortPowerErr)
                    | (trig_q[i][`DSR_BIT_LONG_EN] & powerErr[i].longPowerErr)
                    | (trig_q[i][`DSR_BIT_LINK_EN] & linkErr)
                    | (trig_q[i][`DSR_BIT_ROT_EN] & syncRotate
                       & rotGate_q[`DSR_BIT_ROT_GATE])
                    | (trig_q[i][`DSR_BIT_PIN_EN] & pinFall);
    assign takeOff  = en & (state_q == DSR_ON) & trig_q[i][`DSR_BIT_FORCE_OFF];
    assign takeOn   = en & (state_q == DSR_OFF) & softOn_q[i][`DSR_BIT_FORCE_ON];
    assign stat[i]  = {rampBusy[i], state_q == DSR_OFF, 6'(gain_q)};
    assign gainLevel[i] = gain_q;

    // Level counts once the second and third stages agree
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        pinS1_q  <= 1'b0;
        pinS2_q  <= 1'b0;
        pinS3_q  <= 1'b0;
        pinLvl_q <= 1'b0;
      end else begin
        pinS1_q <= transmit_enable_pin[i];
        pinS2_q <= pinS1_q;
        pinS3_q <= pinS2_q;
        if (pinS2_q == pinS3_q) begin
          pinLvl_q <= pinS2_q;
        end
      end
    end

    // Force bits clear when taken; a software write in the same cycle wins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        ctrl_q[i]   <= `DSR_RST_GAIN_CTRL;
        trig_q[i]   <= `DSR_RST_TRIG_EN;
        softOn_q[i] <= `DSR_RST_SOFT_ON;
      end else begin
        if (takeOff) begin
          trig_q[i][`DSR_BIT_FORCE_OFF] <= 1'b0;
        end
        if (takeOn) begin
          softOn_q[i][`DSR_BIT_FORCE_ON] <= 1'b0;
        end
        if (selW && wrSel == DSR_R_CTRL) begin
          ctrl_q[i] <= wData_q & `DSR_MASK_GAIN_CTRL;
        end
        if (selW && wrSel == DSR_R_TRIG) begin
          trig_q[i] <= wData_q & `DSR_MASK_TRIG_EN;
        end
        if (selW && wrSel == DSR_R_SON) begin
          softOn_q[i] <= wData_q & `DSR_MASK_SOFT_ON;
        end
      end
    end

    // Clearing the master enable freezes a ramp mid-way
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        state_q     <= DSR_ON;
        gain_q      <= GAIN_ONE;
        stepCnt_q   <= '0;
        rampBusy[i] <= 1'b0;
      end else begin
        case (state_q)
          DSR_ON: begin
            if (en & (offReq | trig_q[i][`DSR_BIT_FORCE_OFF])) begin
              state_q     <= DSR_DOWN;
              stepCnt_q   <= '0;
              rampBusy[i] <= 1'b1;
            end
          end
          DSR_DOWN: begin
            if (stepDone) begin
              stepCnt_q <= '0;
              gain_q    <= gain_q - GAIN_W'(1);
              if (gain_q == GAIN_W'(1)) begin
                state_q     <= DSR_OFF;
                rampBusy[i] <= 1'b0;
              end
            end else if (en) begin
              stepCnt_q <= stepCnt_q + CNT_W'(1);
            end
          end
          DSR_OFF: begin
            if (takeOn) begin
              state_q     <= DSR_UP;
              stepCnt_q   <= '0;
              rampBusy[i] <= 1'b1;
            end
          end
          DSR_UP: begin
            if (en & offReq) begin
              state_q   <= DSR_DOWN;
              stepCnt_q <= '0;
            end else if (stepDone) begin
              stepCnt_q <= '0;
              gain_q    <= gain_q + GAIN_W'(1);
              if (gain_q == GAIN_ONE - GAIN_W'(1)) begin
                state_q     <= DSR_ON;
                rampBusy[i] <= 1'b0;
              end
            end else if (en) begin
              stepCnt_q <= stepCnt_q + CNT_W'(1);
            end
          end
          default: begin
            state_q <= DSR_ON;
          end
        endcase
      end
    end

    // Independent step timer for checking
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sinceChg_q <= '0;
      end else if (gain_q != $past(gain_q) || state_q != $past(state_q)) begin
        sinceChg_q <= '0;
      end else if (en) begin
        sinceChg_q <= sinceChg_q + CNT_W'(1);
      end
    end

    property p_masterGate;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_q == DSR_ON && !en) |=> (state_q == DSR_ON && gain_q == GAIN_ONE);
    endproperty
    a_masterGate: assert property (p_masterGate) else $error("ramp began while disabled");

    property p_stepSpacing;
      @(posedge sys_clk) disable iff (sys_rst)
      ($past(state_q) == DSR_DOWN && state_q == DSR_DOWN && $changed(gain_q) && $stable(ctrl_q[i]))
        |-> (sinceChg_q == stepLim);
    endproperty
    a_stepSpacing: assert property (p_stepSpacing) else $error("step length wrong");

    property p_monoDown;
      @(posedge sys_clk) disable iff (sys_rst)
      ($past(state_q) == DSR_DOWN && $changed(gain_q)) |-> (gain_q == $past(gain_q) - GAIN_W'(1));
    endproperty
    a_monoDown: assert property (p_monoDown) else $error("gain not falling by one");

    property p_monoUp;
      @(posedge sys_clk) disable iff (sys_rst)
      ($past(state_q) == DSR_UP && state_q != DSR_DOWN && $changed(gain_q))
        |-> (gain_q == $past(gain_q) + GAIN_W'(1));
    endproperty
    a_monoUp: assert property (p_monoUp) else $error("gain not rising by one");

    property p_shortErr;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_q == DSR_ON && en && trig_q[i][`DSR_BIT_SHORT_EN] && powerErr[i].shortPowerErr)
        |=> (state_q == DSR_DOWN) ##1 rampBusy[i];
    endproperty
    a_shortErr: assert property (p_shortErr) else $error("short error ignored");

    property p_longErr;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_q == DSR_ON && en && trig_q[i][`DSR_BIT_LONG_EN] && powerErr[i].longPowerErr) |=> state_q == DSR_DOWN;
    endproperty
    a_longErr: assert property (p_longErr) else $error("long error ignored");

    property p_linkErr;
      @(posedge sys_clk) disable iff (sys_rst)
      ((state_q == DSR_ON || state_q == DSR_UP) && en && trig_q[i][`DSR_BIT_LINK_EN] && linkErr)
        |=> state_q == DSR_DOWN;
    endproperty
    a_linkErr: assert property (p_linkErr) else $error("link error ignored");

    property p_rotate;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_q == DSR_ON && en && syncRotate && trig_q[i][`DSR_BIT_ROT_EN] && rotGate_q[`DSR_BIT_ROT_GATE])
        |=> state_q == DSR_DOWN;
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotation ignored");

    property p_pinFall;
      @(posedge sys_clk) disable iff (sys_rst)
      ($fell(pinLvl_q) && $past(state_q) == DSR_ON && $past(en) && $past(trig_q[i][`DSR_BIT_PIN_EN]))
        |-> state_q == DSR_DOWN;
    endproperty
    a_pinFall: assert property (p_pinFall) else $error("pin fall ignored");

    property p_forceOff;
      @(posedge sys_clk) disable iff (sys_rst)
      takeOff |=> (state_q == DSR_DOWN && gain_q == GAIN_ONE);
    endproperty
    a_forceOff: assert property (p_forceOff) else $error("force off ignored");

    property p_forceOn;
      @(posedge sys_clk) disable iff (sys_rst)
      takeOn |=> (state_q == DSR_UP && gain_q == '0);
    endproperty
    a_forceOn: assert property (p_forceOn) else $error("force on ignored");

    c_reachedOff: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(state_q == DSR_OFF));
    c_reachedOn:  cover property (@(posedge sys_clk) disable iff (sys_rst) $past(state_q) == DSR_UP
                                  && state_q == DSR_ON);
    c_pinOff:     cover property (@(posedge sys_clk) disable iff (sys_rst) pinFall && state_q == DSR_ON && en);
  end

endmodule : dsr_soft_off_ramp

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`include "dsr_map.svh"

module tb_top;
  import dsr_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic               sys_clk    = 1'b0;
  logic               sys_rst    = 1'b1;
  logic [15:0]        awaddr     = '0;
  logic [15:0]        araddr     = '0;
  logic [31:0]        wdata      = '0;
  logic [3:0]         wstrb      = '0;
  logic               awvalid    = 1'b0;
  logic               wvalid     = 1'b0;
  logic               bready     = 1'b0;
  logic               arvalid    = 1'b0;
  logic               rready     = 1'b0;
  logic               awready;
  logic               wready;
  logic               bvalid;
  logic               arready;
  logic               rvalid;
  logic [1:0]         bresp;
  logic [1:0]         rresp;
  logic [31:0]        rdata;
  dsr_err_t [1:0]     powerErr   = '0;
  logic               linkErr    = 1'b0;
  logic               syncRotate = 1'b0;
  logic [1:0]         txPin      = 2'b11;
  logic [1:0][5:0]    gainLevel;
  logic [1:0]         rampBusy;
  int                 error_cnt  = 0;
  int                 checked    = 0;
  int                 cyc        = 0;

  dsr_soft_off_ramp dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .powerErr(powerErr), .linkErr(linkErr), .syncRotate(syncRotate),
    .transmit_enable_pin(txPin), .gainLevel(gainLevel), .rampBusy(rampBusy)
  );

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Longest run is fourteen ramps at the slowest rate used
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic axWrite(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] expResp);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        chk("bresp", bresp, expResp);
        bready <= 1'b0;
      end
    end
  endtask : axWrite

  task automatic axRead(input logic [11:0] idx, input logic [7:0] exp, input logic [1:0] expResp,
                        input string what);
    logic done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        chk(what, rdata, {24'h0, exp});
        chk("rresp", rresp, expResp);
        rready <= 1'b0;
      end
    end
  endtask : axRead

  // Sources 0..4: short power, long power, link, rotation, pin fall
  task automatic srcSet(input int s, input logic on);
    @(posedge sys_clk);
    case (s)
      0:       powerErr   <= {2{on, 1'b0}};
      1:       powerErr   <= {2{1'b0, on}};
      2:       linkErr    <= on;
      3:       syncRotate <= on;
      default: txPin      <= {2{~on}};
    endcase
  endtask : srcSet

  task automatic flat(input int c);
    repeat (40) @(posedge sys_clk);
    #1;
    chk("gain_hold", gainLevel[c], 32'd32);
    chk("busy_hold", rampBusy[c], 32'd0);
  endtask : flat

  function automatic int stepCycles(input logic [2:0] rate);
    return (1 << (32'(rate) + `DSR_RAMP_EXP_BASE)) / `DSR_RAMP_STEPS;
  endfunction : stepCycles

  // Every step one unit, exactly 2^(rate+3) cycles apart
  task automatic ramp(input int c, input logic down, input logic [2:0] rate);
    int         per;
    int         n;
    logic [5:0] g;
    per = stepCycles(rate);
    g   = down ? 6'd32 : 6'd0;
    for (int k = 0; k < 32; k++) begin
      n = 0;
      while (gainLevel[c] === g && n < 3 * per) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk("gain_step", gainLevel[c], down ? g - 6'd1 : g + 6'd1);
      if (k > 0) chk("step_period", n, per);
      if (k == 16) chk("busy_mid", rampBusy[c], 32'd1);
      g = gainLevel[c];
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk("busy_end", rampBusy[c], 32'd0);
  endtask : ramp

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    logic [2:0] rate;
    int         bitTab [5];
    bitTab = '{7, 6, 3, 2, 1};
    void'($urandom(59));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    axRead(`DSR_IDX_GAIN_CTRL, 8'h00, `DSR_RESP_OKAY, "ctrl_rst");
    axRead(`DSR_IDX_TRIG_EN, 8'hc6, `DSR_RESP_OKAY, "trig_rst");
    axRead(`DSR_IDX_SOFT_ON, 8'h40, `DSR_RESP_OKAY, "son_rst");
    axRead(`DSR_IDX_PAGE, 8'h03, `DSR_RESP_OKAY, "page_rst");
    axRead(`DSR_IDX_ROT_GATE, 8'h00, `DSR_RESP_OKAY, "gate_rst");
    axRead(`DSR_IDX_STATUS, 8'h20, `DSR_RESP_OKAY, "status_rst");
    axRead(12'h004, 8'h00, `DSR_RESP_SLVERR, "unmapped_rd");
    axWrite(12'h004, 8'hff, `DSR_RESP_SLVERR);
    r = 8'($urandom);
    axWrite(`DSR_IDX_GAIN_CTRL, r, `DSR_RESP_OKAY);
    axRead(`DSR_IDX_GAIN_CTRL, r & 8'h87, `DSR_RESP_OKAY, "ctrl_rw");
    axWrite(`DSR_IDX_GAIN_CTRL, 8'h00, `DSR_RESP_OKAY);
    // Master enable off: a held power error must not ramp
    srcSet(0, 1'b1);
    flat(0);
    srcSet(0, 1'b0);
    rate = 3'($urandom_range(2, 0));
    axWrite(`DSR_IDX_GAIN_CTRL, {5'h10, rate}, `DSR_RESP_OKAY);
    axWrite(`DSR_IDX_TRIG_EN, 8'hc7, `DSR_RESP_OKAY);
    ramp(0, 1'b1, rate);
    axRead(`DSR_IDX_STATUS, 8'h40, `DSR_RESP_OKAY, "status_off");
    axRead(`DSR_IDX_TRIG_EN, 8'hc6, `DSR_RESP_OKAY, "force_clr");
    axWrite(`DSR_IDX_SOFT_ON, 8'hc0, `DSR_RESP_OKAY);
    ramp(0, 1'b0, rate);
    axRead(`DSR_IDX_STATUS, 8'h20, `DSR_RESP_OKAY, "status_on");
    // Each source: refused while its enable or gate is clear, then ramps
    for (int s = 0; s < 5; s++) begin
      rate = 3'($urandom_range(2, 0));
      axWrite(`DSR_IDX_GAIN_CTRL, {5'h10, rate}, `DSR_RESP_OKAY);
      axWrite(`DSR_IDX_ROT_GATE, 8'h00, `DSR_RESP_OKAY);
      axWrite(`DSR_IDX_TRIG_EN, (s == 3) ? 8'h04 : 8'h00, `DSR_RESP_OKAY);
      srcSet(s, 1'b1);
      flat(0);
      srcSet(s, 1'b0);
      repeat (8) @(posedge sys_clk);
      axWrite(`DSR_IDX_ROT_GATE, 8'h01, `DSR_RESP_OKAY);
      axWrite(`DSR_IDX_TRIG_EN, 8'h01 << bitTab[s], `DSR_RESP_OKAY);
      srcSet(s, 1'b1);
      ramp(0, 1'b1, rate);
      chk("gain_pair", gainLevel[1], 32'd0);
      srcSet(s, 1'b0);
      repeat (8) @(posedge sys_clk);
      axWrite(`DSR_IDX_SOFT_ON, 8'hc0, `DSR_RESP_OKAY);
      ramp(0, 1'b0, rate);
    end
    // Only the selected converter follows the controls
    axWrite(`DSR_IDX_PAGE, 8'h02, `DSR_RESP_OKAY);
    axWrite(`DSR_IDX_TRIG_EN, 8'h01, `DSR_RESP_OKAY);
    ramp(1, 1'b1, rate);
    chk("gain_other", gainLevel[0], 32'd32);
    axRead(`DSR_IDX_STATUS, 8'h40, `DSR_RESP_OKAY, "status_page");
    axWrite(`DSR_IDX_PAGE, 8'h03, `DSR_RESP_OKAY);
    axWrite(`DSR_IDX_SOFT_ON, 8'hc0, `DSR_RESP_OKAY);
    ramp(1, 1'b0, rate);
    chk("gain_on_only", gainLevel[0], 32'd32);
    conclude();
  end

endmodule : tb_top
